// File: src/dpm_pkg.sv
package dpm_pkg;
   // register map, byte addresses on the plain register port
   localparam int ADDR_W = 20;
   localparam logic [19:0] CTRL_ADDR = 20'h71400;
   localparam logic [19:0] SERIAL_ADDR = 20'h71404;
   localparam logic [19:0] CARD_ID_ADDR = 20'h71408;
   localparam logic [19:0] STATUS_ADDR = 20'h7140C;
   // control register fields
   localparam int C_EN = 0;
   localparam int C_EXTCLK = 1;
   localparam int C_HSA = 2;
   localparam int C_VSA = 3;
   localparam int C_HSB = 4;
   localparam int C_VSB = 5;
   localparam int C_CRTHS = 6;
   localparam int C_CRTVS = 7;
   localparam int C_CRTINT = 8;
   localparam logic [8:0] CTRL_RST = 9'h000;
   localparam logic [7:0] SERIAL_RST = 8'h00;
   // status register fields, line levels sit in bits 7:0
   localparam int ST_FLDA = 8;
   localparam int ST_FLDB = 9;
   localparam int ST_IRQN = 10;
   localparam int ST_CLKIN = 11;
   localparam int ST_DISP = 12;
   localparam int ST_EMPTY = 13;
   localparam int ST_LIVE = 14;
   // serial line order: 0..5 digital (5 sits on ad15), 6..7 analog
   localparam int L_SECDATA = 5;
   localparam logic [7:0] DIGITAL_LINES = 8'h3F;
   // synchronised input vector layout
   localparam int SYNC_W = 21;
   localparam int S_CLKIN = 0;
   localparam int S_FLDA = 1;
   localparam int S_IRQN = 2;
   localparam int S_FLDB = 3;
   localparam int S_LINE = 4;
   localparam int S_PAR = 12;
   localparam int S_SBA = 13;
   // pad codes: 0..31 address/data pins, 32..35 command/byte-enable pins
   localparam int PIN_W = 36;
   localparam logic [5:0] FIRST_MAP [12] = '{6'h03, 6'h02, 6'h05, 6'h04, 6'h07, 6'h06,
                                             6'h08, 6'h20, 6'h0A, 6'h09, 6'h0C, 6'h0B};
   localparam logic [5:0] SECOND_MAP [12] = '{6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h23,
                                              6'h19, 6'h18, 6'h1B, 6'h1A, 6'h1D, 6'h1C};
   localparam logic [5:0] P_HSA = 6'h00;
   localparam logic [5:0] P_VSA = 6'h01;
   localparam logic [5:0] P_BLA = 6'h21;
   localparam logic [5:0] P_HSB = 6'h11;
   localparam logic [5:0] P_VSB = 6'h10;
   localparam logic [5:0] P_BLB = 6'h12;
   localparam int P_CLKIN = 13;
   localparam int P_FLDA = 14;
   localparam int P_SECDATA = 15;
   localparam int P_IRQ = 30;
   localparam int P_FLDB = 31;
   localparam logic [31:0] GAD_OE_MASK = 32'h3FFF1FFF;
   localparam logic [3:0] CBE_OE_MASK = 4'hB;
   // internal pacing: last divider count, one less than the clock cycles per half period of the output clock
   localparam logic [1:0] PACE_LAST = 2'h1;
   localparam int FIFO_DEPTH = 16;
   typedef struct packed {
      logic [23:0] pixB;
      logic [23:0] pixA;
      logic hsB;
      logic vsB;
      logic blankNB;
      logic hsA;
      logic vsA;
      logic blankNA;
   } dpm_word_t;
   localparam dpm_word_t IDLE_WORD = '0;
   typedef enum logic [1:0] {
      CAP_WAIT0 = 2'h0,
      CAP_WAIT1 = 2'h1,
      CAP_WAIT2 = 2'h3,
      CAP_LIVE = 2'h2
   } dpm_cap_t;
endpackage

// File: src/dpm_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser; only the second stage is visible
module dpm_sync #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meta_r <= '0;
         q <= '0;
      end else if (ce) begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// File: src/dpm_fifo.sv
`timescale 1ns/1ps
// word buffer with valid/ready on both sides
module dpm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_r;
   logic [AW:0] rdPtr_r;
   logic push;
   logic pop;

   // extra pointer bit tells full from empty
   assign outValid = wrPtr_r != rdPtr_r;
   assign inReady = wrPtr_r != {~rdPtr_r[AW], rdPtr_r[AW-1:0]};
   assign push = ce && inValid && inReady;
   assign pop = ce && outReady && outValid;
   assign outData = mem[rdPtr_r[AW-1:0]];

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wrPtr_r[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
      end
   end
endmodule

// File: src/dpm_pin_mux.sv
// Our own choice: strobed register access.
`timescale 1ns/1ps
// Behaviour
// RULE1 - aux serial data and both display channel pairs float during reset
// RULE2 - parity pin strap picks graphics-bus or digital-display mode
// RULE3 - in display mode the identifier register holds the card identifier
// RULE4 - the eight sideband address straps are captured as the identifier
// RULE5 - first port pixel bits go to their fixed address/enable pins
// RULE6 - second port pixel bits go to their fixed address/enable pins
// RULE7 - port clock pairs on the strobes, syncs and blanks on fixed pins
// RULE8 - clock-in, irq and field/stall inputs and serial pairs on fixed pins
// RULE9 - aux serial pair is the serial bus toward the digital display
// RULE10 - display channel pairs serve primary and secondary connectors
// RULE11 - analog line sync has selectable polarity or sync-interval mode
// RULE12 - analog frame sync has selectable polarity
// RULE13 - analog channel clock and data are a two-wire open-drain link
// RULE14 - each port moves twelve bits on every output clock edge
// RULE15 - aux serial clock also floats during reset
// RULE16 - straps are sampled at reset release and held until next reset
// RULE17 - in graphics-bus mode no display signal drives a shared pin
module dpm_pin_mux (
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [19:0] addr,
   input wire logic [31:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   output logic [31:0] rdData,
   input wire dpm_pkg::dpm_word_t pixIn,
   input wire logic pixValid,
   output logic pixReady,
   input wire logic crtHsIn,
   input wire logic crtVsIn,
   output logic crtHsync,
   output logic crtVsync,
   input wire logic gparIn,
   input wire logic [7:0] sbaIn,
   input wire logic [31:0] gadIn,
   output logic [31:0] gadOut,
   output logic [31:0] gadOe,
   output logic [3:0] cbeOut,
   output logic [3:0] cbeOe,
   output logic [1:0] stbOut,
   output logic [1:0] stbNOut,
   output logic stbOe,
   input wire logic [6:0] serialIn,
   output logic [6:0] serialOut,
   output logic [6:0] serialOe,
   output logic busMode
);
   logic [dpm_pkg::SYNC_W-1:0] rawAsync;
   logic [dpm_pkg::SYNC_W-1:0] syncQ;
   dpm_pkg::dpm_cap_t capState_r;
   dpm_pkg::dpm_cap_t capState_nxt;
   logic dispMode_r;
   logic [7:0] cardId_r;
   logic live;
   logic display;
   logic [8:0] ctrl_r;
   logic [7:0] serial_r;
   logic [7:0] lineOe;
   logic [31:0] status;
   logic linkLvl_r;
   logic [1:0] divCnt_r;
   logic running;
   logic tick;
   logic phase_r;
   logic fifoValid;
   logic pop;
   dpm_pkg::dpm_word_t fifoWord;
   dpm_pkg::dpm_word_t newWord;
   dpm_pkg::dpm_word_t curWord;
   dpm_pkg::dpm_word_t word_r;
   logic [11:0] halfA;
   logic [11:0] halfB;
   logic [dpm_pkg::PIN_W-1:0] pinNxt;
   logic [31:0] gadOut_r;
   logic [3:0] cbeOut_r;
   logic stbClk_r;
   logic stbClkN_r;
   logic crtHs_r;
   logic crtVs_r;
   logic [31:0] rdData_r;

   // sync polarity: the word carries active-high syncs
   function automatic logic applyPol(input logic lvl, input logic inv);
      return lvl ^ inv;
   endfunction

   // every pin level from the far side is synchronised once, in one bank
   assign rawAsync = {sbaIn, gparIn, serialIn[6:5], gadIn[dpm_pkg::P_SECDATA],
                      serialIn[4:0], gadIn[dpm_pkg::P_FLDB], gadIn[dpm_pkg::P_IRQ],
                      gadIn[dpm_pkg::P_FLDA], gadIn[dpm_pkg::P_CLKIN]}; // RULE8

   dpm_sync #(
      .W(dpm_pkg::SYNC_W)
   ) syncIn (
      .clock(clock),
      .resetn(resetn),
      .ce(ce),
      .d(rawAsync),
      .q(syncQ)
   );

   // strap capture sequence: wait until the synchroniser holds real pin levels
   always_comb begin
      case (capState_r)
         dpm_pkg::CAP_WAIT0: capState_nxt = dpm_pkg::CAP_WAIT1;
         dpm_pkg::CAP_WAIT1: capState_nxt = dpm_pkg::CAP_WAIT2;
         dpm_pkg::CAP_WAIT2: capState_nxt = dpm_pkg::CAP_LIVE;
         dpm_pkg::CAP_LIVE: capState_nxt = dpm_pkg::CAP_LIVE;
         default: capState_nxt = dpm_pkg::CAP_WAIT0;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         capState_r <= dpm_pkg::CAP_WAIT0;
      end else if (ce) begin
         capState_r <= capState_nxt;
      end
   end

   // straps are taken once after release; later pin activity is bus traffic
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         dispMode_r <= 1'b0;
         cardId_r <= 8'h00;
      end else if (ce && capState_r == dpm_pkg::CAP_WAIT2) begin // RULE16
         dispMode_r <= ~syncQ[dpm_pkg::S_PAR]; // RULE2
         cardId_r <= syncQ[dpm_pkg::S_SBA +: 8]; // RULE4
      end
   end

   assign live = capState_r == dpm_pkg::CAP_LIVE;
   assign display = live && dispMode_r;
   assign busMode = !display; // RULE17

   // software registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= dpm_pkg::CTRL_RST;
         serial_r <= dpm_pkg::SERIAL_RST;
      end else if (ce && wrStb) begin
         if (addr == dpm_pkg::CTRL_ADDR) begin
            ctrl_r <= wrData[8:0];
         end
         if (addr == dpm_pkg::SERIAL_ADDR) begin
            serial_r <= wrData[7:0];
         end
      end
   end

   assign status = {17'h00000, live, !fifoValid, dispMode_r,
                    syncQ[dpm_pkg::S_CLKIN], syncQ[dpm_pkg::S_IRQN],
                    syncQ[dpm_pkg::S_FLDB], syncQ[dpm_pkg::S_FLDA],
                    syncQ[dpm_pkg::S_LINE +: 8]};

   // read data stands only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rdData_r <= 32'h00000000;
      end else if (ce) begin
         rdData_r <= 32'h00000000;
         if (rdStb) begin
            case (addr)
               dpm_pkg::CTRL_ADDR: rdData_r <= {23'h000000, ctrl_r};
               dpm_pkg::SERIAL_ADDR: rdData_r <= {24'h000000, serial_r};
               dpm_pkg::CARD_ID_ADDR: rdData_r <= {24'h000000,
                                                   display ? cardId_r : 8'h00}; // RULE3
               dpm_pkg::STATUS_ADDR: rdData_r <= status;
               default: rdData_r <= 32'h00000000;
            endcase
         end
      end
   end
   assign rdData = rdData_r;

   // open-drain lines: pin only ever pulled low, floats under reset
   // digital lines share bus pins, so they are released outside display mode
   assign lineOe = serial_r & (display ? 8'hFF : ~dpm_pkg::DIGITAL_LINES)
                   & {8{resetn}}; // RULE1 RULE15 RULE9 RULE10 RULE13
   assign serialOe = {lineOe[7:6], lineOe[4:0]};
   assign serialOut = 7'h00;

   // pacing: internal divider, or both edges of the far side's clock-in
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         linkLvl_r <= 1'b0;
         divCnt_r <= 2'h0;
      end else if (ce) begin
         linkLvl_r <= syncQ[dpm_pkg::S_CLKIN];
         divCnt_r <= (divCnt_r == dpm_pkg::PACE_LAST) ? 2'h0 : divCnt_r + 2'h1;
      end
   end

   assign running = display && ctrl_r[dpm_pkg::C_EN];
   assign tick = ce && running && (ctrl_r[dpm_pkg::C_EXTCLK] ?
                 (syncQ[dpm_pkg::S_CLKIN] != linkLvl_r) :
                 (divCnt_r == dpm_pkg::PACE_LAST));

   // a word is popped at the start of each output clock period only, so a
   // slow link backs up into the buffer and then into pixReady
   assign pop = tick && !phase_r && fifoValid;

   dpm_fifo #(
      .WIDTH($bits(dpm_pkg::dpm_word_t)),
      .DEPTH(dpm_pkg::FIFO_DEPTH)
   ) pixBuf (
      .clock(clock),
      .resetn(resetn),
      .ce(ce),
      .inData(pixIn),
      .inValid(pixValid),
      .inReady(pixReady),
      .outData(fifoWord),
      .outValid(fifoValid),
      .outReady(pop)
   );

   // an empty buffer sends an idle word rather than stalling the clock
   assign newWord = fifoValid ? fifoWord : dpm_pkg::IDLE_WORD;
   assign curWord = phase_r ? word_r : newWord;
   assign halfA = phase_r ? word_r.pixA[23:12] : newWord.pixA[11:0]; // RULE14
   assign halfB = phase_r ? word_r.pixB[23:12] : newWord.pixB[11:0]; // RULE14

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         phase_r <= 1'b0;
         word_r <= dpm_pkg::IDLE_WORD;
         stbClk_r <= 1'b0;
         stbClkN_r <= 1'b1;
      end else if (tick) begin
         phase_r <= !phase_r;
         stbClk_r <= !phase_r; // RULE14
         stbClkN_r <= phase_r; // RULE7
         if (!phase_r) begin
            word_r <= newWord;
         end
      end
   end

   // scatter both ports onto pad codes
   always_comb begin
      pinNxt = '0;
      for (int i = 0; i < 12; i++) begin
         pinNxt[dpm_pkg::FIRST_MAP[i]] = halfA[i]; // RULE5
         pinNxt[dpm_pkg::SECOND_MAP[i]] = halfB[i]; // RULE6
      end
      pinNxt[dpm_pkg::P_HSA] = applyPol(curWord.hsA, ctrl_r[dpm_pkg::C_HSA]); // RULE7
      pinNxt[dpm_pkg::P_VSA] = applyPol(curWord.vsA, ctrl_r[dpm_pkg::C_VSA]); // RULE7
      pinNxt[dpm_pkg::P_BLA] = curWord.blankNA; // RULE7
      pinNxt[dpm_pkg::P_HSB] = applyPol(curWord.hsB, ctrl_r[dpm_pkg::C_HSB]); // RULE7
      pinNxt[dpm_pkg::P_VSB] = applyPol(curWord.vsB, ctrl_r[dpm_pkg::C_VSB]); // RULE7
      pinNxt[dpm_pkg::P_BLB] = curWord.blankNB; // RULE7
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         gadOut_r <= 32'h00000000;
         cbeOut_r <= 4'h0;
      end else if (tick) begin
         gadOut_r <= pinNxt[31:0];
         cbeOut_r <= pinNxt[35:32];
      end
   end

   // output enables; inputs and the open-drain line never drive push-pull
   assign gadOut = gadOut_r;
   assign cbeOut = cbeOut_r;
   assign gadOe = (display ? dpm_pkg::GAD_OE_MASK : 32'h00000000)
                  | {16'h0000, lineOe[dpm_pkg::L_SECDATA], 15'h0000}; // RULE17 RULE8
   assign cbeOe = display ? dpm_pkg::CBE_OE_MASK : 4'h0; // RULE17
   assign stbOe = display; // RULE17
   assign stbOut = {2{stbClk_r}}; // RULE7
   assign stbNOut = {2{stbClkN_r}}; // RULE7

   // analog syncs, registered so polarity changes never glitch the pins
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         crtHs_r <= 1'b0;
         crtVs_r <= 1'b0;
      end else if (ce) begin
         crtHs_r <= applyPol(ctrl_r[dpm_pkg::C_CRTINT] ? (crtHsIn | crtVsIn) : crtHsIn,
                             ctrl_r[dpm_pkg::C_CRTHS]); // RULE11
         crtVs_r <= applyPol(crtVsIn, ctrl_r[dpm_pkg::C_CRTVS]); // RULE12
      end
   end
   assign crtHsync = crtHs_r;
   assign crtVsync = crtVs_r;

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   serial_hiz_a: assert property ( // RULE1
      @(posedge clock) disable iff (1'b0)
      !resetn |-> (serialOe[4:1] == 4'h0) && !gadOe[dpm_pkg::P_SECDATA])
      else $error("display channel line driven in reset");

   aux_clk_hiz_a: assert property ( // RULE15
      @(posedge clock) disable iff (1'b0)
      !resetn |-> !serialOe[0])
      else $error("aux serial clock driven in reset");

   card_id_read_a: assert property ( // RULE3
      ce && rdStb && addr == dpm_pkg::CARD_ID_ADDR && display
      |=> rdData == {24'h000000, cardId_r} ##1 rdData == 32'h00000000 || $past(rdStb))
      else $error("identifier read wrong");

   strap_capture_a: assert property ( // RULE4
      ce && capState_r == dpm_pkg::CAP_WAIT2
      |=> cardId_r == $past(syncQ[dpm_pkg::S_SBA +: 8]) && live)
      else $error("identifier strap not captured");

   strap_hold_a: assert property ( // RULE16
      live |=> $stable(cardId_r) && $stable(dispMode_r) && live)
      else $error("straps changed after capture");

   mode_strap_a: assert property ( // RULE2
      ce && capState_r == dpm_pkg::CAP_WAIT2
      |=> dispMode_r == !$past(syncQ[dpm_pkg::S_PAR]))
      else $error("mode strap not captured");

   bus_quiet_a: assert property ( // RULE17
      !display |-> gadOe == 32'h00000000 && cbeOe == 4'h0 && !stbOe)
      else $error("display drive in bus mode");

   first_map_a: assert property ( // RULE5
      tick && !phase_r
      |=> gadOut[3] == $past(newWord.pixA[0]) && cbeOut[0] == $past(newWord.pixA[7])
          && gadOut[11] == $past(newWord.pixA[11]))
      else $error("first port pin map wrong");

   second_map_a: assert property ( // RULE6
      tick && phase_r
      |=> gadOut[28] == $past(word_r.pixB[23]) && cbeOut[3] == $past(word_r.pixB[17])
          && gadOut[19] == $past(word_r.pixB[12]))
      else $error("second port pin map wrong");

   clock_pair_a: assert property ( // RULE7
      stbOut == ~stbNOut)
      else $error("clock pair not complementary");

   ddr_edge_a: assert property ( // RULE14
      tick |=> stbOut[0] != $past(stbOut[0]) ##0 $stable(word_r.pixA) || $past(!phase_r))
      else $error("no clock edge for a data half");

   input_pins_a: assert property ( // RULE8
      display |-> !gadOe[dpm_pkg::P_CLKIN] && !gadOe[dpm_pkg::P_FLDA]
                  && !gadOe[dpm_pkg::P_IRQ] && !gadOe[dpm_pkg::P_FLDB])
      else $error("input pin driven");

   crt_hs_a: assert property ( // RULE11
      ce && resetn ##1 ce |-> crtHsync == ($past(ctrl_r[dpm_pkg::C_CRTINT]) ?
         ($past(crtHsIn) | $past(crtVsIn)) : $past(crtHsIn)) ^ $past(ctrl_r[dpm_pkg::C_CRTHS]))
      else $error("analog line sync wrong");

   crt_vs_a: assert property ( // RULE12
      ce && resetn |=> crtVsync == ($past(crtVsIn) ^ $past(ctrl_r[dpm_pkg::C_CRTVS])))
      else $error("analog frame sync wrong");

   analog_line_a: assert property ( // RULE13
      serialOe[6:5] == serial_r[7:6] && serialOut == 7'h00)
      else $error("analog channel drive wrong");
endmodule

// File: bench/dpm_card_model.sv
`timescale 1ns/1ps
// plug-in transmitter card: straps, status inputs, link clock and open-drain lines
module dpm_card_model (
   input wire logic detectN,
   input wire logic [7:0] idVal,
   input wire logic clkRun,
   input wire logic fieldA,
   input wire logic fieldB,
   input wire logic irqN,
   input wire logic pullAux,
   input wire logic [6:0] serialOe,
   input wire logic [31:0] gadOut,
   input wire logic [31:0] gadOe,
   output logic gparIn,
   output logic [7:0] sbaIn,
   output logic [31:0] gadIn,
   output logic [6:0] serialIn
);
   logic clkIn = 1'b0;
   // link clock stands still unless the card is sending
   always begin
      #62.5;
      if (clkRun) clkIn = ~clkIn;
   end
   assign gparIn = detectN;
   assign sbaIn = idVal;
   // card inputs on their pins; released pins show the inverse of the last level
   always_comb begin
      gadIn = gadOe & gadOut | ~gadOe & ~gadOut;
      gadIn[15] = ~(gadOe[15] & ~gadOut[15]);
      gadIn[13] = clkIn;
      gadIn[14] = fieldA;
      gadIn[30] = irqN;
      gadIn[31] = fieldB;
   end
   // pull-ups; the pin mux may pull any line low, the card only the aux data line 1
   always_comb begin
      serialIn = ~serialOe;
      serialIn[1] = ~serialOe[1] & ~pullAux;
   end
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin errors++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb;
   logic clock, resetn, ce, wrStb, rdStb, pixValid, crtHsIn, crtVsIn;
   logic [19:0] addr;
   logic [31:0] wrData, rdData, gadIn, gadOut, gadOe, r;
   dpm_pkg::dpm_word_t pixIn;
   logic pixReady, crtHsync, crtVsync, gparIn, stbOe, busMode;
   logic [7:0] sbaIn, idS;
   logic [3:0] cbeOut, cbeOe;
   logic [1:0] stbOut, stbNOut;
   logic [6:0] serialIn, serialOut, serialOe;
   logic detN, clkRun, fldA, fldB, irqN, pullAux;
   int errors = 0;
   int nTests = 0;
   // pin codes from the mapping: 32 and up are command/byte-enable pins
   int fm[12] = '{3, 2, 5, 4, 7, 6, 8, 32, 10, 9, 12, 11};
   int sm[12] = '{19, 20, 21, 22, 23, 35, 25, 24, 27, 26, 29, 28};
   int sp[6] = '{0, 1, 33, 17, 16, 18};
   dpm_pin_mux u_dut (.clock(clock), .resetn(resetn), .ce(ce), .addr(addr), .wrData(wrData),
      .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .pixIn(pixIn), .pixValid(pixValid),
      .pixReady(pixReady), .crtHsIn(crtHsIn), .crtVsIn(crtVsIn), .crtHsync(crtHsync),
      .crtVsync(crtVsync), .gparIn(gparIn), .sbaIn(sbaIn), .gadIn(gadIn), .gadOut(gadOut),
      .gadOe(gadOe), .cbeOut(cbeOut), .cbeOe(cbeOe), .stbOut(stbOut), .stbNOut(stbNOut),
      .stbOe(stbOe), .serialIn(serialIn), .serialOut(serialOut), .serialOe(serialOe),
      .busMode(busMode));
   dpm_card_model u_card (.detectN(detN), .idVal(idS), .clkRun(clkRun), .fieldA(fldA),
      .fieldB(fldB), .irqN(irqN), .pullAux(pullAux), .serialOe(serialOe), .gadOut(gadOut),
      .gadOe(gadOe), .gparIn(gparIn), .sbaIn(sbaIn), .gadIn(gadIn), .serialIn(serialIn));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge clock);
      wrStb <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [19:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge clock);
      rdStb <= 1'b0;
      #1 d = rdData;
   endtask
   // expected pin levels of one phase, sync bits already after polarity
   function automatic logic [35:0] pins(logic [11:0] a, logic [11:0] b, logic [5:0] s);
      logic [35:0] v;
      v = '0;
      for (int i = 0; i < 12; i++) begin
         v[fm[i]] = a[i];
         v[sm[i]] = b[i];
      end
      for (int i = 0; i < 6; i++) v[sp[i]] = s[5-i];
      return v;
   endfunction
   // reset with new straps; shared lines must float while reset is held
   task automatic t_reset(input logic dn, input logic [7:0] id);
      @(posedge clock);
      resetn <= 1'b0;
      detN <= dn;
      idS <= id;
      cyc(3);
      `CHK("serialOe in reset", 7'h00, serialOe)
      `CHK("aux clock oe in reset", 1'b0, serialOe[0])
      `CHK("gadOe in reset", 32'h0, gadOe)
      @(posedge clock);
      resetn <= 1'b1;
      cyc(6);
   endtask
   task automatic t_ident();
      rd(dpm_pkg::CARD_ID_ADDR, r);
      `CHK("card id", 32'h5A, r)
      @(posedge clock);
      idS <= 8'hC3;
      wr(dpm_pkg::CARD_ID_ADDR, 32'hFF);
      cyc(4);
      rd(dpm_pkg::CARD_ID_ADDR, r);
      `CHK("card id held", 32'h5A, r)
      rd(dpm_pkg::STATUS_ADDR, r);
      `CHK("display mode", 3'b111, {r[14], r[13], r[12]})
      `CHK("busMode", 1'b0, busMode)
      rd(20'h71410, r);
      `CHK("unmapped", 32'h0, r)
   endtask
   // fill the buffer with one word and watch both clock phases on the pins
   task automatic t_pixels(input logic [8:0] ctl, input logic [5:0] inv);
      logic [35:0] mk;
      logic [5:0] s;
      int k;
      mk = pins(12'hFFF, 12'hFFF, 6'h3F);
      s = 6'b101010 ^ inv;
      wr(dpm_pkg::CTRL_ADDR, {23'h0, ctl});
      pixIn <= '{pixB: 24'h6D9E1B, pixA: 24'h3CAA53, hsB: 1'b0, vsB: 1'b1, blankNB: 1'b0,
                 hsA: 1'b1, vsA: 1'b0, blankNA: 1'b1};
      pixValid <= 1'b1;
      k = 0;
      do begin
         cyc(1);
         k++;
      end while (pixReady !== 1'b0 && k < 60);
      `CHK("buffer refuses", 1'b0, pixReady)
      for (int e = 0; e < 3; e++) begin
         k = 0;
         do begin
            cyc(1);
            k++;
         end while (stbOut !== 2'b11 && k < 20);
         `CHK("low half", pins(12'hA53, 12'hE1B, s), {cbeOut, gadOut} & mk)
         `CHK("pin enables", mk, {cbeOe, gadOe} & mk)
         `CHK("clock pair", {~stbOut, 1'b1}, {stbNOut, stbOe})
         k = 0;
         do begin
            cyc(1);
            k++;
         end while (stbOut !== 2'b00 && k < 20);
         `CHK("high half", pins(12'h3CA, 12'h6D9, s), {cbeOut, gadOut} & mk)
      end
      @(posedge clock);
      pixValid <= 1'b0;
      cyc(90);
      rd(dpm_pkg::STATUS_ADDR, r);
      `CHK("buffer drained", 1'b1, r[13])
   endtask
   // count rising output clock edges over a window of cycles
   task automatic count_rise(input int n, output int c);
      logic p;
      c = 0;
      p = stbOut[0];
      repeat (n) begin
         cyc(1);
         if (stbOut[0] === 1'b1 && p === 1'b0) c++;
         p = stbOut[0];
      end
   endtask
   task automatic t_pacing();
      int c;
      wr(dpm_pkg::CTRL_ADDR, 32'h1);
      count_rise(40, c);
      `CHK("internal pace", 1'b1, c >= 9 && c <= 11)
      wr(dpm_pkg::CTRL_ADDR, 32'h3);
      clkRun <= 1'b1;
      cyc(20);
      count_rise(250, c);
      `CHK("link pace", 1'b1, c >= 7 && c <= 9)
      clkRun <= 1'b0;
   endtask
   task automatic t_serial();
      wr(dpm_pkg::SERIAL_ADDR, 32'h3F);
      cyc(1);
      `CHK("digital lines", 8'h9F, {gadOe[15], serialOe})
      wr(dpm_pkg::SERIAL_ADDR, 32'hC0);
      cyc(1);
      `CHK("analog lines", 7'h60, serialOe)
      @(posedge clock);
      pullAux <= 1'b1;
      fldA <= 1'b1;
      irqN <= 1'b0;
      wr(dpm_pkg::SERIAL_ADDR, 32'h0);
      cyc(6);
      rd(dpm_pkg::STATUS_ADDR, r);
      `CHK("line levels", 8'hFD, r[7:0])
      `CHK("card inputs", 3'b001, r[10:8])
      pullAux <= 1'b0;
   endtask
   task automatic t_crt();
      logic [4:0] tv[4] = '{5'b00010, 5'b01110, 5'b00001, 5'b10001};
      logic [1:0] ex[4] = '{2'b10, 2'b01, 2'b01, 2'b11};
      for (int i = 0; i < 4; i++) begin
         wr(dpm_pkg::CTRL_ADDR, {23'h0, tv[i][4:2], 6'h00});
         crtHsIn <= tv[i][1];
         crtVsIn <= tv[i][0];
         cyc(3);
         `CHK("crt syncs", ex[i], {crtHsync, crtVsync})
      end
   endtask
   task automatic t_busmode();
      wr(dpm_pkg::SERIAL_ADDR, 32'h1F);
      t_reset(1'b1, 8'h77);
      wr(dpm_pkg::CTRL_ADDR, 32'h1);
      wr(dpm_pkg::SERIAL_ADDR, 32'h1F);
      cyc(10);
      rd(dpm_pkg::CARD_ID_ADDR, r);
      `CHK("id in bus mode", 32'h0, r)
      `CHK("bus pins free", 14'h0001, {gadOe[7:0] | gadOe[31:24], cbeOe, stbOe, busMode})
      `CHK("digital serial free", 5'h00, serialOe[4:0])
   endtask
   task automatic test_done();
      if (errors == 0 && nTests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      errors++;
      test_done();
   end
   initial begin
      {resetn, wrStb, rdStb, pixValid, crtHsIn, crtVsIn, clkRun, fldA, fldB, pullAux} = '0;
      {ce, irqN} = 2'b11;
      addr = '0;
      wrData = '0;
      pixIn = dpm_pkg::IDLE_WORD;
      detN = 1'b0;
      idS = 8'h5A;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      cyc(6);
      t_ident();
      t_pixels(9'h001, 6'h00);
      t_pixels(9'h03D, 6'b110110);
      t_pacing();
      t_serial();
      t_crt();
      t_busmode();
      test_done();
   end
endmodule
